/* dv/host_control_port_assertions.sv */
// Assertion checker for the host control port
`timescale 1ns/1ps
module hcp_chk (
  input wire clk_i,
  input wire rst_n_i,
  input wire chip_sel_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire sync_n_i,
  input wire test_reset_n_i,
  input wire [7:0] data_oe_n_o,
  input wire gain_strobe_a_n_o,
  input wire gain_strobe_b_n_o,
  input wire chain_flush_o,
  input wire [7:0] osc_phase_o,
  input wire tap_reset_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_tap_follow: assert property (!test_reset_n_i |-> !tap_reset_n_o)
    else $error("tap reset not asserted");
  a_tap_release: assert property ($rose(test_reset_n_i) |-> !tap_reset_n_o ##1 !tap_reset_n_o ##1 tap_reset_n_o)
    else $error("tap reset release timing");
  a_oe_whole: assert property (data_oe_n_o == 8'h00 || data_oe_n_o == 8'hFF)
    else $error("split enable");
  a_bus_drive: assert property ((!chip_sel_n_i && !rd_n_i && wr_n_i)[*4] |-> data_oe_n_o == 8'h00)
    else $error("bus not driven");
  a_bus_release: assert property (rd_n_i[*4] |-> data_oe_n_o == 8'hFF)
    else $error("bus driven");
  a_strobe_a_sync: assert property ((!sync_n_i)[*4] |-> !gain_strobe_a_n_o)
    else $error("strobe a idle");
  a_strobe_b_sync: assert property ((!sync_n_i)[*4] |-> !gain_strobe_b_n_o)
    else $error("strobe b idle");
  a_sync_flush: assert property ((!sync_n_i)[*4] |-> chain_flush_o)
    else $error("no flush");
  a_sync_phase: assert property ((!sync_n_i)[*4] |-> osc_phase_o == 8'h00)
    else $error("phase kept");
  cover property ((!sync_n_i)[*4]);
  cover property (!data_oe_n_o[0]);
  cover property ($fell(chain_flush_o));
  cover property ((!rd_n_i && !wr_n_i && chip_sel_n_i)[*4]);
  cover property ($rose(tap_reset_n_o));
endmodule // hcp_chk
bind host_control_port hcp_chk chk_u (.clk_i, .rst_n_i, .chip_sel_n_i, .rd_n_i, .wr_n_i,
  .sync_n_i, .test_reset_n_i, .data_oe_n_o, .gain_strobe_a_n_o, .gain_strobe_b_n_o,
  .chain_flush_o, .osc_phase_o, .tap_reset_n_o);

/* dv/host_control_port_tb_top.sv */
// Self-checking bench for the host control port
`timescale 1ns/1ps
module host_control_port_tb_top;
  logic clk_i = 0, rst_n_i = 0, sync_n_i = 1, trst_n = 1, req_a = 0, req_b = 0;
  logic rdy, sa, sb, so, fl, tp;
  logic [19:0] dbg = 20'h00000;
  logic [15:0] dith;
  logic [7:0] a, dw, dout, doe, ph, q, oe;
  logic cs, rd, wr;
  int error_cnt = 0, check_count = 0, cyc = 0, n;
  always #12.5 clk_i = ~clk_i;
  host_model host_u (.clk_i(clk_i), .data_o(dout), .data_oe_n_o(doe), .addr_o(a),
    .data_w_o(dw), .cs_n_o(cs), .rd_n_o(rd), .wr_n_o(wr));
  host_control_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(a), .data_i(dw),
    .data_o(dout), .data_oe_n_o(doe), .chip_sel_n_i(cs), .rd_n_i(rd), .wr_n_i(wr),
    .sync_n_i(sync_n_i), .test_reset_n_i(trst_n), .debug_word_i(dbg),
    .gain_strobe_a_req_i(req_a), .gain_strobe_b_req_i(req_b), .ready_o(rdy),
    .gain_strobe_a_n_o(sa), .gain_strobe_b_n_o(sb), .serial_out_drive_enable_o(so),
    .chain_flush_o(fl), .dither_q_o(dith), .osc_phase_o(ph), .tap_reset_n_o(tp));
  task chk(input [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Window of four sample periods, so phase does not matter
  task count_ready(input lvl);
    n = 0;
    repeat (16) begin
      @(negedge clk_i);
      n += (rdy === lvl);
    end
  endtask
  task t_regs;
    host_u.cycle(8'h03, 8'hA5, 0, 0, q, oe);
    host_u.cycle(8'h03, 8'h5A, 1, 0, q, oe);
    chk(q, 8'hA5);
    chk(oe, 8'h00);
    chk(doe, 8'hFF);
    host_u.cycle(8'h04, 8'h3C, 0, 0, q, oe);
    host_u.cycle(8'h04, 8'hC3, 1, 1, q, oe);
    chk(q, 8'h3C);
    host_u.cycle(8'h03, 8'h00, 1, 0, q, oe);
    chk(q, 8'hA5);
    host_u.cycle(8'h05, 8'hFF, 1, 0, q, oe);
    chk(q, 8'h00);
    $display("t_regs done");
  endtask
  task t_ready;
    host_u.cycle(8'h02, 8'h03, 0, 0, q, oe);
    host_u.cycle(8'h00, 8'h02, 0, 0, q, oe);
    chk(so, 1'b1);
    count_ready(1'b1);
    chk(n[15:0], 16'h0004);
    host_u.cycle(8'h00, 8'h01, 0, 0, q, oe);
    chk(so, 1'b0);
    count_ready(1'b0);
    chk(n[15:0], 16'h0004);
    dbg = 20'h00008;
    host_u.cycle(8'h00, 8'h04, 0, 0, q, oe);
    count_ready(1'b1);
    chk(n[15:0], 16'h0010);
    dbg = 20'h00000;
    count_ready(1'b1);
    chk(n[15:0], 16'h0000);
    $display("t_ready done");
  endtask
  task t_sync;
    sync_n_i = 0;
    trst_n = 0;
    repeat (5) @(negedge clk_i);
    chk({fl, sa, sb, ph}, 11'h400);
    chk(dith, 16'hACE1);
    chk(tp, 1'b0);
    sync_n_i = 1;
    req_a = 1;
    repeat (5) @(negedge clk_i);
    chk({fl, sa, sb}, 3'b001);
    trst_n = 1;
    req_a = 0;
    req_b = 1;
    repeat (3) @(negedge clk_i);
    chk({sa, sb, tp}, 3'b101);
    $display("t_sync done");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      summarize;
    end
  end
  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1;
    repeat (3) @(negedge clk_i);
    t_regs;
    t_ready;
    t_sync;
    summarize;
  end
endmodule // host_control_port_tb_top

/* dv/host_model.sv */
// Behavioural host processor driving the control port
`timescale 1ns/1ps
module host_model (
  input wire clk_i,
  input wire [7:0] data_o,
  input wire [7:0] data_oe_n_o,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] data_w_o = 8'hFF,
  output logic cs_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1
);
  // Strobe held four edges: two sync flops, a settle cycle, then the load or
  // output flop
  task automatic cycle(input [7:0] a, d, input rd, ss, output [7:0] q, oe);
    @(negedge clk_i);
    addr_o = a;
    data_w_o = d;
    cs_n_o = ss;
    rd_n_o = !rd;
    wr_n_o = rd && !ss;
    repeat (4) @(negedge clk_i);
    // A released bit reads back inverted, so an undriven read cannot pass
    q = data_o ^ data_oe_n_o;
    oe = data_oe_n_o;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    data_w_o = ~d;
  endtask
endmodule // host_model

/* logic/host_control_port.v */
// Host control port with sync input and programmable-polarity ready flag
// Operation
// - Eight-bit two-way data bus for host register writes and reads.
// - Every register has a unique eight-bit address chosen by host address pins.
// - Drive data bus when chip select low, read low, write high, or when read and write low with chip select high.
// - Read strobe and chip select low put addressed register on bus.
// - Write strobe and chip select low load bus value into addressed register, except the read-only status register.
// - With read held low, write strobe acts as combined read and chip select.
// - Ready flag asserts at the start of every output sample period.
// - Ready flag active level selected by a configuration bit.
// - Ready flag stays driven regardless of serial output drive enable.
// - In debug mode the ready pin carries debug word bit 3.
// - Sync input is registered on the rising clock edge before use.
// - Sync resets decimation counter, dither generator and oscillator phase.
// - Sync discards all sample data held in the processing chain.
// - Both gain strobes stay asserted while sync is asserted.
// - Test reset asynchronously resets the test access controller.
// - Master reset clears all registers except decimation (loaded with 07) and holds both gain strobes asserted.
`timescale 1ns/1ps
`include "host_port_regs.vh"
module host_control_port #(
  parameter ADDR_W = `ADDR_W,
  parameter DATA_W = `DATA_W
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [DATA_W-1:0] data_i,
  output reg [DATA_W-1:0] data_o,
  output reg [DATA_W-1:0] data_oe_n_o,
  input wire chip_sel_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire sync_n_i,
  input wire test_reset_n_i,
  input wire [19:0] debug_word_i,
  input wire gain_strobe_a_req_i,
  input wire gain_strobe_b_req_i,
  output reg ready_o,
  output reg gain_strobe_a_n_o,
  output reg gain_strobe_b_n_o,
  output reg serial_out_drive_enable_o,
  output reg chain_flush_o,
  output reg [15:0] dither_q_o,
  output reg [7:0] osc_phase_o,
  output reg tap_reset_n_o
);
  // Pin inputs: address, data and strobes pass two flops
  wire [ADDR_W-1:0] addr_s;
  wire [DATA_W-1:0] data_s;
  wire cs_n_s;
  wire rd_n_s;
  wire wr_n_s;
  wire sync_n_s;
  pin_sync #(.WIDTH(ADDR_W + DATA_W + 4),
    .RESET_VAL({{(ADDR_W + DATA_W){1'b0}}, 4'hF})) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({addr_i, data_i, chip_sel_n_i, rd_n_i, wr_n_i, sync_n_i}),
    .sync_o({addr_s, data_s, cs_n_s, rd_n_s, wr_n_s, sync_n_s})
  );

  // Register file, flip-flops indexed by address
  reg [DATA_W-1:0] regs_q [0:`NUM_REGS-1];
  reg wr_act_q;
  reg wr_act_qq;
  reg [7:0] decim_cnt_q;
  reg [7:0] status_q;

  // Single-strobe mode: read held low turns write strobe into read/select
  wire single_mode = ~rd_n_s & ~wr_n_s & cs_n_s;
  wire read_act = (~cs_n_s & ~rd_n_s & wr_n_s) | single_mode;
  wire wr_act = ~cs_n_s & ~wr_n_s & rd_n_s;
  // Load once, one cycle after the synced leading edge: address and data bits
  // cross on their own flops and get a cycle to settle before they are used
  wire wr_pulse = wr_act & wr_act_q & ~wr_act_qq;
  wire [31:0] addr_idx = {{(32 - ADDR_W){1'b0}}, addr_s};
  wire sync_act = ~sync_n_s;

  wire [7:0] cfg = regs_q[`ADDR_CONFIG];
  wire rdy_pol = cfg[`CFG_RDY_POL_BIT];
  wire debug_mode = cfg[`CFG_DEBUG_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_REGS; gi = gi + 1) begin : g_reg
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          regs_q[gi] <= (gi == `ADDR_DECIM) ? `DECIM_RESET : `REG_RESET;
        end else if (wr_pulse && addr_idx == gi && gi != `ADDR_STATUS) begin
          regs_q[gi] <= data_s;
        end
      end
    end
  endgenerate

  reg [DATA_W-1:0] rd_data;
  always @* begin
    if (addr_s == `ADDR_STATUS) begin
      rd_data = status_q;
    end else begin
      rd_data = regs_q[addr_s];
    end
  end

  // Write strobe history for the one-shot load
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_act_q <= 1'b0;
      wr_act_qq <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      wr_act_qq <= wr_act_q;
    end
  end

  // Sample-period counter; sync forces it back to the start of a period
  wire osp_start = (decim_cnt_q == 8'h00);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      decim_cnt_q <= 8'h00;
    end else if (sync_act) begin
      decim_cnt_q <= 8'h00;
    end else if (osp_start) begin
      decim_cnt_q <= regs_q[`ADDR_DECIM];
    end else begin
      decim_cnt_q <= decim_cnt_q - 8'h01;
    end
  end

  // Dither shift register; restarting from the seed makes dither repeatable
  wire dither_fb = dither_q_o[15] ^ dither_q_o[13] ^ dither_q_o[12] ^ dither_q_o[10];
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dither_q_o <= `DITHER_SEED;
    end else if (sync_act) begin
      dither_q_o <= `DITHER_SEED;
    end else begin
      dither_q_o <= {dither_q_o[14:0], dither_fb};
    end
  end

  // Oscillator phase accumulator
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_phase_o <= 8'h00;
    end else if (sync_act) begin
      osc_phase_o <= 8'h00;
    end else begin
      osc_phase_o <= osc_phase_o + 8'h01;
    end
  end

  // Status word and flush of the processing chain
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_q <= `REG_RESET;
      chain_flush_o <= 1'b1;
    end else begin
      status_q <= {5'h00, debug_mode, sync_act, osp_start};
      chain_flush_o <= sync_act;
    end
  end

  // Data bus; output data follows the address even while the bus is released
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= `REG_RESET;
      data_oe_n_o <= {DATA_W{1'b1}};
    end else begin
      data_o <= rd_data;
      data_oe_n_o <= read_act ? {DATA_W{1'b0}} : {DATA_W{1'b1}};
    end
  end

  // Ready flag ignores the serial drive enable so the host never misses a period
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else if (debug_mode) begin
      ready_o <= debug_word_i[3];
    end else begin
      ready_o <= osp_start ^ rdy_pol;
    end
  end

  // Gain strobes, held asserted through master reset and sync
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gain_strobe_a_n_o <= 1'b0;
      gain_strobe_b_n_o <= 1'b0;
    end else begin
      gain_strobe_a_n_o <= ~(sync_act | gain_strobe_a_req_i);
      gain_strobe_b_n_o <= ~(sync_act | gain_strobe_b_req_i);
    end
  end

  // Serial drive enable mirrors its configuration bit
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_out_drive_enable_o <= 1'b0;
    end else begin
      serial_out_drive_enable_o <= cfg[`CFG_SERIAL_OUT_DRIVE_ENABLE_BIT];
    end
  end

  // Test controller reset asserts with no clock; release passes two flops so
  // the controller never leaves reset on a runt edge
  wire tap_clr_n = rst_n_i & test_reset_n_i;
  reg tap_meta_q;
  always @(posedge clk_i or negedge tap_clr_n) begin
    if (!tap_clr_n) begin
      tap_meta_q <= 1'b0;
      tap_reset_n_o <= 1'b0;
    end else begin
      tap_meta_q <= 1'b1;
      tap_reset_n_o <= tap_meta_q;
    end
  end
endmodule // host_control_port

/* logic/host_port_regs.vh */
// Constants for the host control port, sync and ready flag block
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
`define ADDR_W 8
`define DATA_W 8
`define NUM_REGS 256
`define REG_RESET 8'h00
`define ADDR_CONFIG 8'h00
`define CFG_RDY_POL_BIT 0
`define CFG_SERIAL_OUT_DRIVE_ENABLE_BIT 1
`define CFG_DEBUG_BIT 2
`define ADDR_STATUS 8'h01
`define ADDR_DECIM 8'h02
`define DECIM_RESET 8'h07
`define DITHER_SEED 16'hACE1
`endif

/* logic/pin_sync.v */
// Two-flop synchroniser for a bus of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // pin_sync
